/* File: aesb_encrypt.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module aesb_encrypt
  import aesb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  // DMA master
  output logic             dma_req,
  output logic             dma_we,
  output logic      [31:0] dma_addr,
  output logic      [31:0] dma_wdata,
  input  wire logic        dma_ack,
  input  wire logic [31:0] dma_rdata,
  // Shared cipher core arbitration
  output logic             core_req,
  input  wire logic        core_gnt
);

  // ==========================================================
  // Cipher functions
  function automatic logic [7:0] xt(input logic [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] t;
    p = 8'h00;
    t = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ t;
      t = xt(t);
    end
    gf_mul = p;
  endfunction

  // Inverse as x^254, then the affine map; no table keeps the file small
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] r;
    r = a;
    for (int i = 0; i < 6; i++)
      r = gf_mul(gf_mul(r, r), a);
    r = gf_mul(r, r);
    sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ SBOX_AFFINE;
  endfunction

  function automatic logic [127:0] key_next(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] t;
    logic [127:0] o;
    t = {sbox(k[23:16]), sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])} ^ {rc, 24'h00_0000};
    o[127:96] = k[127:96] ^ t;
    o[95:64]  = k[95:64] ^ o[127:96];
    o[63:32]  = k[63:32] ^ o[95:64];
    o[31:0]   = k[31:0] ^ o[63:32];
    key_next = o;
  endfunction

  // Byte n of the state sits at [127-8n -: 8]; column c holds bytes 4c..4c+3
  function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] k,
                                             input logic last);
    logic [7:0] b [16];
    logic [7:0] m [16];
    logic [127:0] o;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        b[4*c+r] = sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        m[4*c+r] = xt(b[4*c+r]) ^ xt(b[4*c+(r+1)%4]) ^ b[4*c+(r+1)%4]
                 ^ b[4*c+(r+2)%4] ^ b[4*c+(r+3)%4];
    for (int n = 0; n < 16; n++)
      o[127-8*n -: 8] = last ? b[n] : m[n];
    aes_round = o ^ k;
  endfunction

  // Memory is little endian; the cipher state is byte 0 first
  function automatic logic [31:0] bswap(input logic [31:0] w);
    bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  function automatic logic [31:0] word_addr(input logic [31:0] p, input logic [5:0] ofs,
                                            input logic [2:0] w);
    word_addr = p + {26'h000_0000, ofs} + {28'h000_0000, w[1:0], 2'b00};
  endfunction

  function automatic logic in_dram(input logic [31:0] p);
    in_dram = (p >= DRAM_BASE)
            && (({1'b0, p} + STRUCT_LAST) < ({1'b0, DRAM_BASE} + {1'b0, DRAM_SIZE}));
  endfunction

  // ==========================================================
  // State
  aesb_regs_t r;
  aesb_regs_t n;
  logic       wr_start;
  logic       wr_stop;
  logic       ack_w;

  assign wr_start = reg_wr && (reg_addr == OFS_START) && reg_wdata[0];
  assign wr_stop  = reg_wr && (reg_addr == OFS_ABORT) && reg_wdata[0];
  assign ack_w    = r.dma_req && dma_ack;

  always_comb
  begin
    logic set_done;
    logic set_abort;
    logic stopping;
    set_done  = 1'b0;
    set_abort = 1'b0;
    stopping  = wr_stop || r.stop_pend;
    n = r;
    n.rdata = 32'h0000_0000;

    // ==========================================================
    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_DONE:    if (!reg_wdata[0]) n.ev_done = 1'b0;
        OFS_ABORTED: if (!reg_wdata[0]) n.ev_aborted = 1'b0;
        OFS_IRQ_SET: n.inten = r.inten | reg_wdata[1:0];
        OFS_IRQ_CLR: n.inten = r.inten & ~reg_wdata[1:0];
        OFS_PTR:     n.ptr = reg_wdata;
        default:     ;
      endcase
    end

    // ==========================================================
    // Block sequencer
    unique case (r.st)
      ST_IDLE:
      begin
        n.stop_pend = 1'b0;
        if (wr_start)
        begin
          if (in_dram(r.ptr))
          begin
            n.st       = ST_FETCH;
            n.idx      = 3'h0;
            n.dma_req  = 1'b1;
            n.dma_we   = 1'b0;
            n.dma_addr = word_addr(r.ptr, OFS_KEY, 3'h0);
          end
          else
            set_abort = 1'b1;
        end
      end
      ST_FETCH:
      begin
        // A started transfer always runs to its acknowledge
        if (wr_stop)
          n.stop_pend = 1'b1;
        if (dma_ack)
        begin
          if (r.idx[2])
            n.blk[(3-int'(r.idx[1:0]))*32 +: 32] = bswap(dma_rdata);
          else
            n.key[(3-int'(r.idx[1:0]))*32 +: 32] = bswap(dma_rdata);
          n.idx = r.idx + 3'h1;
          n.dma_addr = word_addr(r.ptr, (r.idx[2] || (r.idx == 3'h3)) ? OFS_CLEAR : OFS_KEY,
                                 r.idx + 3'h1);
          if (stopping)
          begin
            n.st      = ST_IDLE;
            n.dma_req = 1'b0;
            set_abort = 1'b1;
          end
          else if (r.idx == LAST_WORD_RD)
          begin
            n.st       = ST_CLAIM;
            n.dma_req  = 1'b0;
            n.core_req = 1'b1;
          end
        end
      end
      ST_CLAIM:
      begin
        if (wr_stop)
        begin
          n.st       = ST_IDLE;
          n.core_req = 1'b0;
          set_abort  = 1'b1;
        end
        else if (core_gnt)
        begin
          n.st    = ST_ROUND;
          n.blk   = r.blk ^ r.key;
          n.rcon  = RCON_INIT;
          n.round = 4'h1;
        end
      end
      ST_ROUND:
      begin
        if (wr_stop || !core_gnt)
        begin
          n.st       = ST_IDLE;
          n.core_req = 1'b0;
          set_abort  = 1'b1;
        end
        else
        begin
          n.key   = key_next(r.key, r.rcon);
          n.blk   = aes_round(r.blk, key_next(r.key, r.rcon), r.round == LAST_ROUND);
          n.rcon  = xt(r.rcon);
          n.round = r.round + 4'h1;
          if (r.round == LAST_ROUND)
          begin
            n.st        = ST_STORE;
            n.core_req  = 1'b0;
            n.idx       = 3'h0;
            n.dma_req   = 1'b1;
            n.dma_we    = 1'b1;
            n.dma_addr  = word_addr(r.ptr, OFS_CIPHER, 3'h0);
            n.dma_wdata = bswap(n.blk[127:96]);
          end
        end
      end
      ST_STORE:
      begin
        if (wr_stop)
          n.stop_pend = 1'b1;
        if (dma_ack)
        begin
          n.idx       = r.idx + 3'h1;
          n.dma_addr  = word_addr(r.ptr, OFS_CIPHER, r.idx + 3'h1);
          // Index wraps so the last ack never selects outside the block
          n.dma_wdata = bswap(r.blk[(3-int'(2'(r.idx[1:0] + 2'h1)))*32 +: 32]);
          if (stopping)
          begin
            n.st      = ST_IDLE;
            n.dma_req = 1'b0;
            n.dma_we  = 1'b0;
            set_abort = 1'b1;
          end
          else if (r.idx == LAST_WORD_WR)
          begin
            n.st      = ST_IDLE;
            n.dma_req = 1'b0;
            n.dma_we  = 1'b0;
            set_done  = 1'b1;
          end
        end
      end
    endcase

    // Hardware set wins over a software clear in the same cycle
    if (set_done)
      n.ev_done = 1'b1;
    if (set_abort)
      n.ev_aborted = 1'b1;
    n.irq = |({n.ev_aborted, n.ev_done} & n.inten);

    // ==========================================================
    // Register reads
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_DONE:    n.rdata = {31'h0000_0000, r.ev_done};
        OFS_ABORTED: n.rdata = {31'h0000_0000, r.ev_aborted};
        OFS_IRQ_SET: n.rdata = {30'h0000_0000, r.inten};
        OFS_IRQ_CLR: n.rdata = {30'h0000_0000, r.inten};
        OFS_BUSY:    n.rdata = {31'h0000_0000, r.st != ST_IDLE};
        OFS_PTR:     n.rdata = r.ptr;
        default:     n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

  assign reg_rdata = r.rdata;
  assign irq       = r.irq;
  assign dma_req   = r.dma_req;
  assign dma_we    = r.dma_we;
  assign dma_addr  = r.dma_addr;
  assign dma_wdata = r.dma_wdata;
  assign core_req  = r.core_req;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [15:0] busy_cyc;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      busy_cyc <= 16'h0000;
    else if (r.st == ST_IDLE)
      busy_cyc <= 16'h0000;
    else if (busy_cyc != 16'hffff)
      busy_cyc <= busy_cyc + 16'h0001;
  end

  idle_no_dma_a: assert property (r.st == ST_IDLE |-> !dma_req && !core_req)
    else $error("DMA or core request while idle");
  done_after_store_a: assert property (r.ev_done && !$past(r.ev_done)
    |-> $past(r.st == ST_STORE && r.idx == LAST_WORD_WR && ack_w))
    else $error("Done raised without last ciphertext write");
  stop_aborts_a: assert property ((r.st == ST_ROUND || r.st == ST_CLAIM) && wr_stop
    |=> r.st == ST_IDLE && r.ev_aborted && !core_req)
    else $error("Abort task did not end the block");
  grant_loss_a: assert property (r.st == ST_ROUND && !core_gnt && !wr_stop
    |=> r.st == ST_IDLE && r.ev_aborted)
    else $error("Lost grant did not abort the block");
  dma_window_a: assert property (dma_req |-> dma_addr >= DRAM_BASE
    && {1'b0, dma_addr} < {1'b0, DRAM_BASE} + {1'b0, DRAM_SIZE})
    else $error("DMA outside data RAM");
  cipher_offset_a: assert property (dma_req && dma_we
    |-> dma_addr - r.ptr >= 32'h0000_0020 && dma_addr - r.ptr <= 32'h0000_002c)
    else $error("Ciphertext written outside its field");
  round_owns_core_a: assert property (r.st == ST_ROUND |-> core_req && r.round >= 4'h1)
    else $error("Rounds run without the core claimed");
  fetch_before_claim_a: assert property (r.st == ST_CLAIM && $past(r.st) != ST_CLAIM
    |-> $past(r.st == ST_FETCH && r.idx == LAST_WORD_RD && ack_w))
    else $error("Core claimed before key and cleartext fetched");
  irq_set_a: assert property (reg_wr && reg_addr == OFS_IRQ_SET && reg_wdata[1]
    |=> r.inten[BIT_ABORTED])
    else $error("Interrupt enable set failed");
  irq_clr_a: assert property (reg_wr && reg_addr == OFS_IRQ_CLR && reg_wdata[0]
    |=> !r.inten[BIT_DONE])
    else $error("Interrupt enable clear failed");
  irq_level_a: assert property ((r.ev_done && r.inten[BIT_DONE])
    || (r.ev_aborted && r.inten[BIT_ABORTED]) |-> irq)
    else $error("Interrupt low with enabled flag set");
  ptr_write_a: assert property (reg_wr && reg_addr == OFS_PTR
    |=> r.ptr == $past(reg_wdata))
    else $error("Pointer write lost");

  done_cov: cover property (r.st == ST_STORE ##1 r.st == ST_IDLE && r.ev_done);
  fast_block_cov: cover property (r.ev_done && !$past(r.ev_done)
    && busy_cyc <= 16'(BLOCK_CYC));
  stop_cov: cover property (r.st == ST_FETCH && wr_stop ##[1:20] r.ev_aborted);
  grant_cov: cover property (r.st == ST_ROUND && !core_gnt);

endmodule

/* File: aesb_pkg.sv */
// Summary of operation
// - Encrypts one 128-bit block with a 128-bit key; there is no decrypt path.
// - Start fetches key and cleartext over DMA before any cipher round.
// - Done event rises only after the last ciphertext word is written.
// - The abort task stops any block that is in progress.
// - Any block ending without completion raises the aborted event.
// - Shared core gives us lowest priority; a claim by others during the rounds aborts the block.
// - DMA reaches the data RAM window only, unless the pointer is rewritten while a block runs.
// - No DMA access is outstanding when done or aborted is raised.
// - Structure: key at byte 0, cleartext at 16, ciphertext at 32.
// - Start task at offset 0x000, abort task at offset 0x004.
// - Done flag at offset 0x100, aborted flag at offset 0x104.
// - Writing ones at 0x304 enables interrupts; reads show enables.
// - Writing ones at 0x308 disables interrupts; reads show enables.
// - Structure pointer is a writable register at offset 0x504.
// - One block with its transfers takes about 6 us typical.
package aesb_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] OFS_START   = 12'h000;
  localparam logic [11:0] OFS_ABORT   = 12'h004;
  localparam logic [11:0] OFS_DONE    = 12'h100;
  localparam logic [11:0] OFS_ABORTED = 12'h104;
  localparam logic [11:0] OFS_IRQ_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFS_BUSY    = 12'h400;
  localparam logic [11:0] OFS_PTR     = 12'h504;
  localparam int          BIT_DONE    = 0;
  localparam int          BIT_ABORTED = 1;

  // ==========================================================
  // Data structure and memory window
  localparam logic [5:0]  OFS_KEY     = 6'h00;
  localparam logic [5:0]  OFS_CLEAR   = 6'h10;
  localparam logic [5:0]  OFS_CIPHER  = 6'h20;
  localparam logic [32:0] STRUCT_LAST = 33'h0_0000_002f;
  localparam logic [31:0] DRAM_BASE   = 32'h1000_0000;
  localparam logic [31:0] DRAM_SIZE   = 32'h0001_0000;

  // ==========================================================
  // Cipher constants
  localparam logic [7:0]  RCON_INIT   = 8'h01;
  localparam logic [7:0]  GF_POLY     = 8'h1b;
  localparam logic [7:0]  SBOX_AFFINE = 8'h63;
  localparam logic [3:0]  LAST_ROUND  = 4'ha;
  localparam logic [2:0]  LAST_WORD_RD = 3'h7;
  localparam logic [2:0]  LAST_WORD_WR = 3'h3;

  // ==========================================================
  // Timing
  localparam int          CLK_MHZ       = 100;
  localparam int          BLOCK_TIME_US = 6;
  localparam int          BLOCK_CYC     = BLOCK_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_CLAIM, ST_ROUND, ST_STORE} aesb_state_t;

  typedef struct packed {
    aesb_state_t  st;
    logic [31:0]  ptr;
    logic [127:0] key;
    logic [127:0] blk;
    logic [7:0]   rcon;
    logic [3:0]   round;
    logic [2:0]   idx;
    logic         stop_pend;
    logic         ev_done;
    logic         ev_aborted;
    logic [1:0]   inten;
    logic         irq;
    logic [31:0]  rdata;
    logic         dma_req;
    logic         dma_we;
    logic [31:0]  dma_addr;
    logic [31:0]  dma_wdata;
    logic         core_req;
  } aesb_regs_t;

endpackage

/* File: aesb_ram_model.sv */
`timescale 1ns/1ns
module aesb_ram_model
  import aesb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // DMA slave side
  input  wire logic        dma_req,
  input  wire logic        dma_we,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_wdata,
  output logic             dma_ack,
  output logic      [31:0] dma_rdata,
  // Behaviour control and observation
  input  wire logic        slow,
  output logic             stray
);
  logic [31:0] mem [0:63];
  logic [1:0]  wait_cnt;
  logic [31:0] ofs;

  assign ofs = dma_addr - DRAM_BASE;

  // ==========================================================
  // Access engine
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dma_ack   <= 1'b0;
      dma_rdata <= 32'h0000_0000;
      wait_cnt  <= 2'h0;
      stray     <= 1'b0;
    end
    else
    begin
      dma_ack   <= 1'b0;
      // Read data is only valid in the ack cycle; keep it moving so stale data never looks valid
      dma_rdata <= ~dma_rdata;
      if (dma_req && !dma_ack)
      begin
        if (wait_cnt == (slow ? 2'h3 : 2'h0))
        begin
          dma_ack  <= 1'b1;
          wait_cnt <= 2'h0;
          // Anything outside the data RAM window is flagged for the bench
          if (dma_addr < DRAM_BASE || ofs >= DRAM_SIZE)
            stray <= 1'b1;
          if (dma_we)
            mem[ofs[7:2]] <= dma_wdata;
          else
            dma_rdata <= mem[ofs[7:2]];
        end
        else
          wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top
  import aesb_pkg::*;
;
  localparam logic [31:0]  PTR = DRAM_BASE + 32'h0000_0040;
  localparam logic [127:0] KEY = 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100;
  localparam logic [127:0] PT  = 128'hffee_ddcc_bbaa_9988_7766_5544_3322_1100;
  localparam logic [127:0] CT  = 128'h5ac5_b470_80b7_cdd8_3004_7b6a_d8e0_c469;

  logic        clk;
  logic        arst_n    = 1'b0;
  logic [11:0] reg_addr  = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        dma_req;
  logic        dma_we;
  logic [31:0] dma_addr;
  logic [31:0] dma_wdata;
  logic        dma_ack;
  logic [31:0] dma_rdata;
  logic        core_req;
  logic        core_gnt  = 1'b0;
  logic        gnt_block = 1'b0;
  logic        slow      = 1'b0;
  logic        stray;
  logic        core_q    = 1'b0;
  logic        dma_seen  = 1'b0;
  int          rd_cnt    = 0;
  int          wr_cnt    = 0;
  int          core_rd   = 0;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc_cnt   = 0;

  aesb_encrypt dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata), .core_req(core_req), .core_gnt(core_gnt));

  aesb_ram_model ram (.clk(clk), .arst_n(arst_n), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata), .slow(slow), .stray(stray));

  // ==========================================================
  // Clock, arbiter stand-in, monitors
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Higher-priority users are modelled by gnt_block taking the core away
  always @(posedge clk)
    core_gnt <= core_req && !gnt_block;

  always @(posedge clk)
  begin
    if (dma_req && dma_ack && dma_we)
      wr_cnt++;
    if (dma_req && dma_ack && !dma_we)
      rd_cnt++;
    if (core_req && !core_q)
      core_rd = rd_cnt;
    if (dma_req)
      dma_seen = 1'b1;
    core_q <= core_req;
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, irq}, 32'h0000_0001);
  endtask

  task automatic load_block();
    #1;
    for (int i = 0; i < 4; i++)
    begin
      ram.mem[16 + i] = KEY[32 * i +: 32];
      ram.mem[20 + i] = PT[32 * i +: 32];
      ram.mem[24 + i] = 32'h0000_0000;
    end
    rd_cnt   = 0;
    wr_cnt   = 0;
    core_rd  = 0;
    dma_seen = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd_chk(OFS_PTR, 32'h0000_0000);
    rd_chk(OFS_IRQ_SET, 32'h0000_0000);
    rd_chk(OFS_DONE, 32'h0000_0000);
    rd_chk(OFS_ABORTED, 32'h0000_0000);
    rd_chk(12'h7fc, 32'h0000_0000);
    wr(OFS_PTR, PTR);
    rd_chk(OFS_PTR, PTR);
    wr(OFS_IRQ_SET, 32'h0000_0003);
    rd_chk(OFS_IRQ_CLR, 32'h0000_0003);
    wr(OFS_IRQ_CLR, 32'h0000_0001);
    rd_chk(OFS_IRQ_SET, 32'h0000_0002);
    wr(OFS_IRQ_SET, 32'h0000_0000);
    rd_chk(OFS_IRQ_SET, 32'h0000_0002);
    wr(OFS_IRQ_CLR, 32'h0000_0000);
    rd_chk(OFS_IRQ_CLR, 32'h0000_0002);
    wr(OFS_IRQ_CLR, 32'h0000_0002);
    rd_chk(OFS_IRQ_SET, 32'h0000_0000);
  endtask

  task automatic t_encrypt(input logic s);
    int n;
    load_block();
    slow = s;
    wr(OFS_PTR, PTR);
    wr(OFS_IRQ_SET, 32'h0000_0001);
    wr(OFS_START, 32'h0000_0001);
    wait_irq(n);
    check(32'(core_rd), 32'h0000_0008);
    check({31'h0, dma_req}, 32'h0000_0000);
    check(32'(wr_cnt), 32'h0000_0004);
    for (int i = 0; i < 4; i++)
      check(ram.mem[24 + i], CT[32 * i +: 32]);
    if (!s)
      check({31'h0, n <= BLOCK_CYC}, 32'h0000_0001);
    rd_chk(OFS_DONE, 32'h0000_0001);
    rd_chk(OFS_ABORTED, 32'h0000_0000);
    wr(OFS_DONE, 32'h0000_0001);
    rd_chk(OFS_DONE, 32'h0000_0001);
    wr(OFS_DONE, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    wr(OFS_IRQ_CLR, 32'h0000_0003);
  endtask

  task automatic t_grant_loss();
    int n;
    load_block();
    slow = 1'b0;
    wr(OFS_IRQ_SET, 32'h0000_0002);
    wr(OFS_START, 32'h0000_0001);
    n = 0;
    while (core_gnt !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (3) @(posedge clk);
    gnt_block <= 1'b1;
    wait_irq(n);
    gnt_block <= 1'b0;
    check({31'h0, core_req}, 32'h0000_0000);
    check(32'(wr_cnt), 32'h0000_0000);
    rd_chk(OFS_ABORTED, 32'h0000_0001);
    rd_chk(OFS_DONE, 32'h0000_0000);
    wr(OFS_ABORTED, 32'h0000_0000);
  endtask

  task automatic t_abort_fetch();
    int n;
    load_block();
    slow = 1'b1;
    wr(OFS_START, 32'h0000_0001);
    n = 0;
    while (rd_cnt < 2 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    rd_chk(OFS_BUSY, 32'h0000_0001);
    wr(OFS_ABORT, 32'h0000_0001);
    wait_irq(n);
    check({31'h0, dma_req}, 32'h0000_0000);
    rd_chk(OFS_BUSY, 32'h0000_0000);
    check({31'h0, rd_cnt < 8}, 32'h0000_0001);
    check(32'(core_rd), 32'h0000_0000);
    rd_chk(OFS_ABORTED, 32'h0000_0001);
    rd_chk(OFS_DONE, 32'h0000_0000);
    wr(OFS_ABORTED, 32'h0000_0000);
  endtask

  task automatic t_refuse();
    wr(OFS_ABORT, 32'h0000_0001);
    rd_chk(OFS_ABORTED, 32'h0000_0000);
    load_block();
    // Pointer deliberately outside data RAM
    wr(OFS_PTR, 32'h0000_0100);
    wr(OFS_START, 32'h0000_0001);
    repeat (4) @(posedge clk);
    #1;
    check({31'h0, dma_seen}, 32'h0000_0000);
    rd_chk(OFS_ABORTED, 32'h0000_0001);
    wr(OFS_ABORTED, 32'h0000_0000);
    wr(OFS_IRQ_CLR, 32'h0000_0003);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_encrypt(1'b0);
    t_encrypt(1'b1);
    t_grant_loss();
    t_abort_fetch();
    t_refuse();
    check({31'h0, stray}, 32'h0000_0000);
    complete_run();
  end
endmodule
